// file: rtl/gfc_map.svh
// Register offsets, field positions, reset values and timing counts for the pin function block
`ifndef GFC_MAP_SVH
`define GFC_MAP_SVH
`define GFC_PIN_CFG_ADDR       8'h24
`define GFC_DEV_MODE_ADDR      8'h25
`define GFC_STATUS_ADDR        8'h23
`define GFC_PIN_CFG_RESET      16'h0000
`define GFC_DEV_MODE_RESET     16'h0000
`define GFC_DEV_MODE_MASK      16'h2300
`define GFC_PIN_CFG_MASK       16'hBFFF
`define GFC_FILT_BIT           15
`define GFC_OE_BIT             13
`define GFC_OSEL_HI            12
`define GFC_OSEL_LO            9
`define GFC_CHSEL_HI           8
`define GFC_CHSEL_LO           5
`define GFC_IFUNC_HI           4
`define GFC_IFUNC_LO           1
`define GFC_IE_BIT             0
`define GFC_LPDIS_BIT          13
`define GFC_PACT_HI            9
`define GFC_PACT_LO            8
`define GFC_PFLAG_BIT          8
`define GFC_FILTER_NS          200
`define GFC_CLK_NS             25
`define GFC_FILTER_CYC         ((`GFC_FILTER_NS + `GFC_CLK_NS - 1) / `GFC_CLK_NS)
`endif

// file: rtl/gfc_pkg.sv
// Types shared by the pin function block
package gfc_pkg;
    typedef enum logic [3:0] {
        GFC_FN_SLEEP   = 4'h0,
        GFC_FN_FDUMP   = 4'h2,
        GFC_FN_IPWR    = 4'h3,
        GFC_FN_VPWR    = 4'h4,
        GFC_FN_PROT    = 4'h5,
        GFC_FN_CLEAR   = 4'h7,
        GFC_FN_LOAD    = 4'h8,
        GFC_FN_WAVE    = 4'h9,
        GFC_FN_MARGIN  = 4'hA,
        GFC_FN_RESET   = 4'hB,
        GFC_FN_NVMWP   = 4'hC,
        GFC_FN_LOCK    = 4'hD
    } gfc_func_e;

    typedef enum logic [1:0] {
        GFC_PS_IDLE  = 2'b00,
        GFC_PS_PREP  = 2'b01,
        GFC_PS_PDN   = 2'b11
    } gfc_prot_e;

    // Internal status feeding the output mux and the protect sequence
    typedef struct packed {
        logic memory_busy;
        logic ch1_busy;
        logic ch0_busy;
        logic window_compare_ch1;
        logic window_compare_ch0;
        logic prep_done;
    } gfc_status_s;

    // Per-channel one-cycle action pulses, index 0 = channel 0
    typedef struct packed {
        logic [1:0] ipwr_down;
        logic [1:0] ipwr_up;
        logic [1:0] vpwr_down;
        logic [1:0] vpwr_up;
        logic [1:0] load_output;
        logic [1:0] wave_stop;
        logic [1:0] wave_start;
        logic [1:0] margin_low;
        logic [1:0] margin_high;
    } gfc_chan_act_s;

    // Device-wide actions
    typedef struct packed {
        logic deep_sleep;
        logic fault_dump;
        logic clear_n;
        logic dev_reset;
        logic nvm_write_ok;
        logic reg_locked;
        logic prot_load_nvm;
        logic prot_margin_low;
        logic prot_margin_high;
        logic prot_hiz;
    } gfc_glob_act_s;
endpackage

// file: rtl/gfc_pin_filter.sv
// Two-flop synchroniser and optional glitch filter for the pin input
`timescale 1ns/1ps
module gfc_pin_filter
(
    // Clock and reset
    input  wire logic sys_clk_i,
    input  wire logic reset_i,
    // Pin and control
    input  wire logic pin_i,
    input  wire logic filter_enable_i,
    // Conditioned level
    output logic      level_o
);
`include "gfc_map.svh"
    localparam logic [7:0] FILT_CYC = 8'(`GFC_FILTER_CYC);

    logic       sync_a;
    logic       sync_b;
    logic [7:0] stable_cnt;
    logic       level;
    logic [7:0] next_stable_cnt;
    logic       next_level;

    // Filter: new level only after holding steady FILT_CYC cycles
    always_comb
    begin
        next_stable_cnt = 8'h00;
        next_level      = level;
        if (!filter_enable_i)
        begin
            next_level = sync_b;
        end
        else if (sync_b != level)
        begin
            next_stable_cnt = stable_cnt + 8'h01;
            if (stable_cnt + 8'h01 >= FILT_CYC)
            begin
                next_level      = sync_b;
                next_stable_cnt = 8'h00;
            end
        end
    end

    // Synchroniser and filter state; pin idles high
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            sync_a     <= 1'b1;
            sync_b     <= 1'b1;
            stable_cnt <= 8'h00;
            level      <= 1'b1;
        end
        else
        begin
            sync_a     <= pin_i;
            sync_b     <= sync_a;
            stable_cnt <= next_stable_cnt;
            level      <= next_level;
        end
    end

    assign level_o = level;
endmodule

// file: rtl/gfc_pin_function.sv
// Multi-function pin: configuration registers, output status mux and input actions
`timescale 1ns/1ps
module gfc_pin_function
(
    // Clock and reset
    input  wire logic                   sys_clk_i,
    input  wire logic                   reset_i,
    // Register port: 8-bit address, 16-bit data
    input  wire logic [7:0]             reg_addr_i,
    input  wire logic                   reg_wr_i,
    input  wire logic                   reg_rd_i,
    input  wire logic [15:0]            reg_wdata_i,
    input  wire logic                   unlock_field_wr_i,
    input  wire logic                   nvm_cfg_valid_i,
    input  wire logic [15:0]            nvm_pin_cfg_i,
    output logic [15:0]                 reg_rdata_o,
    // Device status
    input  wire gfc_pkg::gfc_status_s   status_i,
    // Pin
    input  wire logic                   pin_i,
    output logic                        pin_o,
    output logic                        pin_oe_o,
    // Actions
    output gfc_pkg::gfc_chan_act_s      chan_act_o,
    output gfc_pkg::gfc_glob_act_s      glob_act_o,
    output logic                        low_power_disable_o
);
    import gfc_pkg::*;
`include "gfc_map.svh"

    logic [15:0]   pin_cfg;
    logic [15:0]   dev_mode;
    logic          lvl_q;
    logic          prot_flag;
    gfc_prot_e     prot_st;
    gfc_chan_act_s chan_act;
    gfc_glob_act_s glob_act;
    logic [15:0]   rdata;
    logic          pin_out;
    logic          pin_oe;

    logic [15:0]   next_pin_cfg;
    logic [15:0]   next_dev_mode;
    logic          next_prot_flag;
    gfc_prot_e     next_prot_st;
    gfc_chan_act_s next_chan_act;
    gfc_glob_act_s next_glob_act;
    logic [15:0]   next_rdata;
    logic          next_pin_out;
    logic          next_pin_oe;

    logic          lvl;
    logic          fall;
    logic          rise;
    logic [3:0]    func;
    logic [1:0]    ch_en;
    logic          prot_trig;
    logic          wr_ok;

    gfc_pin_filter u_filter
    (
        .sys_clk_i       (sys_clk_i),
        .reset_i         (reset_i),
        .pin_i           (pin_i),
        .filter_enable_i (pin_cfg[`GFC_FILT_BIT]),
        .level_o         (lvl)
    );

    // Edge detection on the conditioned level, gated by input enable
    assign fall  = pin_cfg[`GFC_IE_BIT] && lvl_q && !lvl;
    assign rise  = pin_cfg[`GFC_IE_BIT] && !lvl_q && lvl;
    assign func  = pin_cfg[`GFC_IFUNC_HI:`GFC_IFUNC_LO];
    // Field bit 3 steers channel 0, bit 0 channel 1
    assign ch_en = {pin_cfg[`GFC_CHSEL_LO], pin_cfg[`GFC_CHSEL_HI]};
    assign prot_trig = fall && (func == GFC_FN_PROT);
    // Writes blocked while locked, except the unlock field
    assign wr_ok = reg_wr_i && !glob_act.reg_locked;

    // Register writes and read data
    always_comb
    begin
        next_pin_cfg  = pin_cfg;
        next_dev_mode = dev_mode;
        next_rdata    = 16'h0000;
        if (wr_ok && reg_addr_i == `GFC_PIN_CFG_ADDR)
        begin
            next_pin_cfg = reg_wdata_i & `GFC_PIN_CFG_MASK;
        end
        if (wr_ok && reg_addr_i == `GFC_DEV_MODE_ADDR)
        begin
            next_dev_mode = reg_wdata_i & `GFC_DEV_MODE_MASK;
        end
        if (reg_rd_i)
        begin
            unique case (reg_addr_i)
                `GFC_PIN_CFG_ADDR:  next_rdata = pin_cfg;
                `GFC_DEV_MODE_ADDR: next_rdata = dev_mode;
                `GFC_STATUS_ADDR:   next_rdata = 16'(prot_flag) << `GFC_PFLAG_BIT;
                default:            next_rdata = 16'h0000;
            endcase
        end
    end

    // Protect sequence and sticky flag; hardware set wins over read clear
    always_comb
    begin
        next_prot_st   = prot_st;
        next_prot_flag = prot_flag;
        if (reg_rd_i && reg_addr_i == `GFC_STATUS_ADDR)
        begin
            next_prot_flag = 1'b0;
        end
        unique case (prot_st)
            GFC_PS_IDLE:
            begin
                if (prot_trig)
                begin
                    next_prot_st = (dev_mode[`GFC_PACT_HI:`GFC_PACT_LO] == 2'b00) ? GFC_PS_PDN : GFC_PS_PREP;
                end
            end
            GFC_PS_PREP:
            begin
                if (status_i.prep_done)
                begin
                    next_prot_st = GFC_PS_PDN;
                end
            end
            GFC_PS_PDN:
            begin
                next_prot_st = GFC_PS_PDN;                      // held until reset
            end
            default:
            begin
                next_prot_st = GFC_PS_IDLE;
            end
        endcase
        if (prot_trig || prot_st != GFC_PS_IDLE)
        begin
            next_prot_flag = 1'b1;
        end
    end

    // Action generation from input function code
    always_comb
    begin
        next_chan_act = '0;
        next_glob_act = glob_act;
        next_glob_act.fault_dump = 1'b0;
        next_glob_act.clear_n    = 1'b1;
        unique case (func)
            GFC_FN_SLEEP:
            begin
                if (fall) next_glob_act.deep_sleep = 1'b1;
                if (rise) next_glob_act.deep_sleep = 1'b0;
            end
            GFC_FN_FDUMP:  next_glob_act.fault_dump = fall;
            GFC_FN_IPWR:
            begin
                next_chan_act.ipwr_down = {2{fall}} & ch_en;
                next_chan_act.ipwr_up   = {2{rise}} & ch_en;
            end
            GFC_FN_VPWR:
            begin
                next_chan_act.vpwr_down = {2{fall}} & ch_en;
                next_chan_act.vpwr_up   = {2{rise}} & ch_en;
            end
            GFC_FN_CLEAR:  next_glob_act.clear_n = !(pin_cfg[`GFC_IE_BIT] && !lvl);
            GFC_FN_LOAD:   next_chan_act.load_output = {2{fall}} & ch_en;
            GFC_FN_WAVE:
            begin
                next_chan_act.wave_stop  = {2{fall}} & ch_en;
                next_chan_act.wave_start = {2{rise}} & ch_en;
            end
            GFC_FN_MARGIN:
            begin
                next_chan_act.margin_low  = {2{fall}} & ch_en;
                next_chan_act.margin_high = {2{rise}} & ch_en;
            end
            GFC_FN_RESET:
            begin
                if (fall) next_glob_act.dev_reset = 1'b1;
                if (rise) next_glob_act.dev_reset = 1'b0;
            end
            GFC_FN_NVMWP:
            begin
                if (fall) next_glob_act.nvm_write_ok = 1'b1;
                if (rise) next_glob_act.nvm_write_ok = 1'b0;
            end
            GFC_FN_LOCK:
            begin
                if (fall) next_glob_act.reg_locked = 1'b0;
                if (rise) next_glob_act.reg_locked = 1'b1;
            end
            default:       next_chan_act = '0;
        endcase
        if (unlock_field_wr_i)
        begin
            next_glob_act.reg_locked = 1'b0;
        end
        next_glob_act.prot_load_nvm    = (next_prot_st == GFC_PS_PREP) && (dev_mode[9:8] == 2'b01);
        next_glob_act.prot_margin_low  = (next_prot_st == GFC_PS_PREP) && (dev_mode[9:8] == 2'b10);
        next_glob_act.prot_margin_high = (next_prot_st == GFC_PS_PREP) && (dev_mode[9:8] == 2'b11);
        next_glob_act.prot_hiz         = (next_prot_st == GFC_PS_PDN);
    end

    // Output mux; unassigned codes drive low
    always_comb
    begin
        next_pin_oe  = pin_cfg[`GFC_OE_BIT];
        next_pin_out = 1'b0;
        unique case (pin_cfg[`GFC_OSEL_HI:`GFC_OSEL_LO])
            4'h1:    next_pin_out = status_i.memory_busy;
            4'h4:    next_pin_out = status_i.ch1_busy;
            4'h7:    next_pin_out = status_i.ch0_busy;
            4'h8:    next_pin_out = status_i.window_compare_ch1;
            4'hB:    next_pin_out = status_i.window_compare_ch0;
            default: next_pin_out = 1'b0;
        endcase
    end

    // State registers; a pin reset reloads the stored config from memory
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            pin_cfg   <= `GFC_PIN_CFG_RESET;
            dev_mode  <= `GFC_DEV_MODE_RESET;
            lvl_q     <= 1'b1;
            prot_flag <= 1'b0;
            prot_st   <= GFC_PS_IDLE;
            chan_act  <= '0;
            glob_act  <= '{clear_n: 1'b1, default: 1'b0};
            rdata     <= 16'h0000;
            pin_out   <= 1'b0;
            pin_oe    <= 1'b0;
        end
        else if (glob_act.dev_reset)
        begin
            // Pin reset: only a stored configuration survives
            pin_cfg   <= nvm_cfg_valid_i ? (nvm_pin_cfg_i & `GFC_PIN_CFG_MASK) : `GFC_PIN_CFG_RESET;
            dev_mode  <= `GFC_DEV_MODE_RESET;
            lvl_q     <= lvl;
            prot_st   <= GFC_PS_IDLE;
            prot_flag <= 1'b0;
            chan_act  <= '0;
            glob_act  <= '{clear_n: 1'b1, dev_reset: !rise, default: 1'b0};
            rdata     <= 16'h0000;
            pin_out   <= 1'b0;
            pin_oe    <= 1'b0;
        end
        else
        begin
            pin_cfg   <= next_pin_cfg;
            dev_mode  <= next_dev_mode;
            lvl_q     <= lvl;
            prot_flag <= next_prot_flag;
            prot_st   <= next_prot_st;
            chan_act  <= next_chan_act;
            glob_act  <= next_glob_act;
            rdata     <= next_rdata;
            pin_out   <= next_pin_out;
            pin_oe    <= next_pin_oe;
        end
    end

    assign reg_rdata_o         = rdata;
    assign pin_o               = pin_out;
    assign pin_oe_o            = pin_oe;
    assign chan_act_o          = chan_act;
    assign glob_act_o          = glob_act;
    assign low_power_disable_o = dev_mode[`GFC_LPDIS_BIT];

    // Checks
    sequence s_fall_load;
        fall && func == GFC_FN_LOAD && !glob_act.dev_reset;
    endsequence
    property p_load;
        @(posedge sys_clk_i) disable iff (reset_i) s_fall_load |=> chan_act.load_output == $past(ch_en);
    endproperty
    a_load: assert property (p_load) else $error("load action mismatch");
    property p_oe;
        @(posedge sys_clk_i) disable iff (reset_i) !pin_cfg[`GFC_OE_BIT] && !glob_act.dev_reset |=> !pin_oe;
    endproperty
    a_oe: assert property (p_oe) else $error("pin driven while output disabled");
    property p_noin;
        @(posedge sys_clk_i) disable iff (reset_i) !pin_cfg[`GFC_IE_BIT] |-> !fall && !rise;
    endproperty
    a_noin: assert property (p_noin) else $error("edge seen with input disabled");
    property p_sleep;
        @(posedge sys_clk_i) disable iff (reset_i)
            fall && func == GFC_FN_SLEEP && !glob_act.dev_reset |=> glob_act.deep_sleep;
    endproperty
    a_sleep: assert property (p_sleep) else $error("deep sleep not entered");
    property p_dump;
        @(posedge sys_clk_i) disable iff (reset_i) glob_act.fault_dump |-> $past(func) == GFC_FN_FDUMP;
    endproperty
    a_dump: assert property (p_dump) else $error("fault dump without code");
    property p_pflag;
        @(posedge sys_clk_i) disable iff (reset_i) prot_trig && !glob_act.dev_reset |=> prot_flag [*2];
    endproperty
    a_pflag: assert property (p_pflag) else $error("protect flag not held");
    property p_wave;
        @(posedge sys_clk_i) disable iff (reset_i)
            rise && func == GFC_FN_WAVE && !glob_act.dev_reset |=> chan_act.wave_start == $past(ch_en);
    endproperty
    a_wave: assert property (p_wave) else $error("waveform start mismatch");
    property p_lock;
        @(posedge sys_clk_i) disable iff (reset_i)
            glob_act.reg_locked && !unlock_field_wr_i && !glob_act.dev_reset |=> $stable(dev_mode);
    endproperty
    a_lock: assert property (p_lock) else $error("write while locked");
endmodule

// file: tb/gfc_pin_host.sv
// Host-side model driving the multi-function pin
`timescale 1ns/1ps
module gfc_pin_host
(
    // Clock
    input  wire logic sys_clk_i,
    // Requested level, glitch and drive
    input  wire logic level_i,
    input  wire logic glitch_i,
    input  wire logic drive_i,
    // Pin drive
    output logic      pin_o
);
    logic toggle = 1'b0;
    // Released pin moves every cycle so a stale level never looks valid
    always @(posedge sys_clk_i)
        toggle <= ~toggle;
    // Glitch inverts the level while held
    assign pin_o = drive_i ? (level_i ^ glitch_i) : toggle;
endmodule

// file: tb/gfc_pin_function_tb.sv
// Self-checking bench for the multi-function pin block
`timescale 1ns/1ps
`include "gfc_map.svh"
module gfc_pin_function_tb;
    import gfc_pkg::*;
    logic sys_clk_i = 0, reset_i = 1, wr = 0, rd = 0, ulk = 0, nv = 0, lvl = 1, gl = 0, rd_d = 0;
    logic [7:0] addr = 0;
    logic [15:0] wd = 0, nvc = 0, rdata;
    logic [31:0] e, r;
    logic [3:0] c;
    logic [4:0] s;
    gfc_status_s st = '0;
    gfc_chan_act_s ca;
    gfc_glob_act_s ga;
    logic po, poe, lpd, hp, pw;
    int n_mismatch = 0, compares = 0, cyc = 0, fd = 0, fd0, lat, lat_f;
    logic [31:0] qr[$];
    gfc_chan_act_s qa[$];
    logic [3:0] codes[9] = '{4'h3, 4'h4, 4'h8, 4'h9, 4'hA, 4'h1, 4'h6, 4'hE, 4'hF};
    logic [4:0] sels[5] = '{5'h11, 5'h18, 5'h19, 5'h10, 5'h09};
    logic [3:0] glc[4] = '{4'h0, 4'hB, 4'hC, 4'hD};

    // Pin wire: device wins while its output enable is high
    assign pw = poe ? po : hp;
    gfc_pin_host i_host (.sys_clk_i(sys_clk_i), .level_i(lvl), .glitch_i(gl), .drive_i(1'b1), .pin_o(hp));
    gfc_pin_function i_dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .reg_addr_i(addr), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_wdata_i(wd), .unlock_field_wr_i(ulk), .nvm_cfg_valid_i(nv),
        .nvm_pin_cfg_i(nvc), .reg_rdata_o(rdata), .status_i(st), .pin_i(pw), .pin_o(po),
        .pin_oe_o(poe), .chan_act_o(ca), .glob_act_o(ga), .low_power_disable_o(lpd));

    // Free-running clock, 25 ns period
    initial
        forever #12.5 sys_clk_i = ~sys_clk_i;

    task automatic test_done;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [17:0] g, input logic [17:0] x);
        compares++;
        if (g !== x)
        begin
            n_mismatch++;
            $display("BAD %0t got %h exp %h", $time, g, x);
        end
    endtask

    task automatic wreg(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk_i);
        addr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge sys_clk_i);
        wr <= 1'b0;
    endtask

    // Read note carries a mask in the upper half
    task automatic rreg(input logic [7:0] a, input logic [15:0] m, input logic [15:0] x);
        @(posedge sys_clk_i);
        addr <= a;
        rd <= 1'b1;
        qr.push_back({m, x});
        @(posedge sys_clk_i);
        rd <= 1'b0;
    endtask

    // Long enough for the filtered path to settle
    task automatic pin(input logic v);
        @(posedge sys_clk_i);
        lvl <= v;
        repeat (16) @(posedge sys_clk_i);
    endtask

    task automatic rst;
        @(posedge sys_clk_i);
        reset_i <= 1'b1;
        lvl <= 1'b1;
        repeat (12) @(posedge sys_clk_i);
        reset_i <= 1'b0;
    endtask

    function automatic logic omux(input logic [3:0] k);
        case (k)
            4'h1: return st.memory_busy;
            4'h4: return st.ch1_busy;
            4'h7: return st.ch0_busy;
            4'h8: return st.window_compare_ch1;
            4'hB: return st.window_compare_ch0;
            default: return 1'b0;
        endcase
    endfunction

    function automatic gfc_chan_act_s act(input logic [3:0] k, input logic [1:0] m, input logic f);
        gfc_chan_act_s a;
        a = '0;
        case (k)
            4'h3: if (f) a.ipwr_down = m; else a.ipwr_up = m;
            4'h4: if (f) a.vpwr_down = m; else a.vpwr_up = m;
            4'h8: if (f) a.load_output = m;
            4'h9: if (f) a.wave_stop = m; else a.wave_start = m;
            4'hA: if (f) a.margin_low = m; else a.margin_high = m;
            default: a = '0;
        endcase
        return a;
    endfunction

    function automatic logic glv(input logic [3:0] k);
        case (k)
            4'h0: return ga.deep_sleep;
            4'hB: return ga.dev_reset;
            4'hC: return ga.nvm_write_ok;
            default: return ga.reg_locked;
        endcase
    endfunction

    function automatic logic pv(input logic [1:0] k);
        case (k)
            2'd0: return ga.prot_hiz;
            2'd1: return ga.prot_load_nvm;
            2'd2: return ga.prot_margin_low;
            default: return ga.prot_margin_high;
        endcase
    endfunction

    // Note an expected pulse, if any, then move the pin
    task automatic step(input logic [1:0] m, input logic v);
        gfc_chan_act_s a;
        a = act(c, m, !v);
        if (a != '0)
            qa.push_back(a);
        pin(v);
    endtask

    // Cycles from driving a falling edge to the load pulse
    task automatic measure(output int n);
        qa.push_back(act(4'h8, 2'b11, 1'b1));
        @(posedge sys_clk_i);
        lvl <= 1'b0;
        n = 0;
        while (ca === '0 && n < 40)
        begin
            @(posedge sys_clk_i);
            n++;
        end
        pin(1'b1);
    endtask

    // Result watcher: oldest note against each read word or pulse
    always @(posedge sys_clk_i)
    begin
        cyc <= cyc + 1;
        if (rd_d)
        begin
            e = qr.pop_front();
            chk(rdata & e[31:16], e[15:0]);
        end
        if (ca !== '0)
            chk(ca, (qa.size() == 0) ? '0 : qa.pop_front());
        if (ga.fault_dump === 1'b1)
            fd++;
        rd_d <= rd;
        // Limit reached: count it and close the run
        if (cyc == 20000)
        begin
            n_mismatch++;
            test_done();
        end
    end

    // Main sequence
    initial
    begin
        r = $urandom(32'hFD8B);
        rst();
        chk(ga.clear_n, 1'b1);
        rreg(`GFC_PIN_CFG_ADDR, 16'hFFFF, 16'h0000);
        rreg(`GFC_DEV_MODE_ADDR, 16'hFFFF, 16'h0000);
        rreg(8'h26, 16'hFFFF, 16'h0000);
        wreg(`GFC_DEV_MODE_ADDR, 16'hFFFF);
        rreg(`GFC_DEV_MODE_ADDR, 16'hFFFF, 16'h2300);
        chk(lpd, 1'b1);
        wreg(`GFC_PIN_CFG_ADDR, 16'hFFFF);
        rreg(`GFC_PIN_CFG_ADDR, 16'hFFFF, 16'hBFFF);
        // Output select sweep, enable on and off, random status
        for (int i = 0; i < 32; i++)
        begin
            r = $urandom;
            st <= r[5:0];
            wreg(`GFC_PIN_CFG_ADDR, {2'b00, i[4], i[3:0], 9'h000});
            repeat (3) @(posedge sys_clk_i);
            chk(poe, i[4]);
            if (i[4])
                chk(po, omux(i[3:0]));
        end
        // Hand the pin back to the host and let the level settle before inputs turn on
        wreg(`GFC_PIN_CFG_ADDR, 16'h0000);
        repeat (6) @(posedge sys_clk_i);
        // Channel codes against every selection, last with input off
        for (int i = 0; i < 45; i++)
        begin
            c = codes[i % 9];
            s = sels[i / 9];
            wreg(`GFC_PIN_CFG_ADDR, {7'h00, s[3:0], c, s[4]});
            step({s[0], s[3]} & {2{s[4]}}, 1'b0);
            step({s[0], s[3]} & {2{s[4]}}, 1'b1);
        end
        // Filter adds its delay; a short glitch is swallowed
        wreg(`GFC_PIN_CFG_ADDR, 16'h0131);
        measure(lat);
        wreg(`GFC_PIN_CFG_ADDR, 16'h8131);
        measure(lat_f);
        chk(18'(lat_f - lat), 18'(`GFC_FILTER_CYC - 1));
        @(posedge sys_clk_i);
        gl <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        gl <= 1'b0;
        repeat (20) @(posedge sys_clk_i);
        // Global levels; stored config survives the pin reset
        nv <= 1'b1;
        foreach (glc[j])
        begin
            c = glc[j];
            nvc <= {11'h000, c, 1'b1};
            wreg(`GFC_PIN_CFG_ADDR, {11'h000, c, 1'b1});
            pin(1'b0);
            chk(glv(c), c != 4'hD);
            pin(1'b1);
            chk(glv(c), c == 4'hD);
            rreg(`GFC_PIN_CFG_ADDR, 16'hFFFF, {11'h000, c, 1'b1});
        end
        wreg(`GFC_PIN_CFG_ADDR, 16'h0000);
        rreg(`GFC_PIN_CFG_ADDR, 16'hFFFF, 16'h001B);
        @(posedge sys_clk_i);
        ulk <= 1'b1;
        @(posedge sys_clk_i);
        ulk <= 1'b0;
        wreg(`GFC_PIN_CFG_ADDR, 16'h000F);
        pin(1'b0);
        chk(ga.clear_n, 1'b0);
        pin(1'b1);
        chk(ga.clear_n, 1'b1);
        wreg(`GFC_PIN_CFG_ADDR, 16'h0005);
        fd0 = fd;
        pin(1'b0);
        pin(1'b1);
        chk(18'(fd - fd0), 18'd1);
        // Pin reset without stored config clears it
        nv <= 1'b0;
        wreg(`GFC_PIN_CFG_ADDR, 16'h0017);
        pin(1'b0);
        chk(ga.dev_reset, 1'b1);
        rreg(`GFC_PIN_CFG_ADDR, 16'hFFFF, 16'h0000);
        // Each protect action, then power-down and the flag
        for (int i = 0; i < 4; i++)
        begin
            rst();
            st <= '0;
            wreg(`GFC_DEV_MODE_ADDR, {6'h00, i[1:0], 8'h00});
            wreg(`GFC_PIN_CFG_ADDR, 16'h000B);
            pin(1'b0);
            chk(pv(i[1:0]), 1'b1);
            st <= 6'h01;
            repeat (8) @(posedge sys_clk_i);
            chk(ga.prot_hiz, 1'b1);
            rreg(`GFC_STATUS_ADDR, 16'h0100, 16'h0100);
            pin(1'b1);
        end
        repeat (20) @(posedge sys_clk_i);
        chk(18'(qa.size()), 18'd0);
        test_done();
    end
endmodule
